/* rtl/gdp_pkg.sv */
/*
 Package for the general purpose port bank: register offsets, field positions,
 reset values, masks and the port count. Assumes a byte-addressed plain register port.
*/
package gdp_pkg;
    // Data registers.
    localparam logic [7:0] DATA_ONE_OFS    = 8'h4b;
    localparam logic [7:0] DATA_TWO_OFS    = 8'h4c;
    localparam logic [7:0] DATA_THREE_OFS  = 8'h4d;
    localparam logic [7:0] DATA_FOUR_OFS   = 8'h4e;
    localparam logic [7:0] DATA_FIVE_OFS   = 8'h4f;
    // Configuration registers, one per port, indexed from this base.
    localparam logic [7:0] CFG_BASE_OFS    = 8'h80;
    // Interrupt status and mask.
    localparam logic [7:0] IRQ_STAT_OFS    = 8'h60;
    localparam logic [7:0] IRQ_MASK_OFS    = 8'h64;
    localparam logic [7:0] IRQ_STAT2_OFS   = 8'h61;
    localparam logic [7:0] IRQ_MASK2_OFS   = 8'h65;
    localparam logic [7:0] IRQ_STAT3_OFS   = 8'h62;
    localparam logic [7:0] IRQ_MASK3_OFS   = 8'h66;
    localparam logic [7:0] IRQ_STAT4_OFS   = 8'h63;
    localparam logic [7:0] IRQ_MASK4_OFS   = 8'h67;
    localparam logic [7:0] IRQ_STAT5_OFS   = 8'h68;
    localparam logic [7:0] IRQ_MASK5_OFS   = 8'h69;
    // Configuration fields.
    localparam int         CFG_DIR_BIT     = 0;
    localparam int         CFG_POL_BIT     = 1;
    localparam int         CFG_ODRAIN_BIT  = 7;
    localparam logic [7:0] CFG_RESET       = 8'h01;
    localparam logic [7:0] DATA_RESET      = 8'h00;
    localparam logic [7:0] FOUR_VALID_MASK = 8'h0f;
    localparam int         NUM_PORTS       = 40;
endpackage

/* rtl/gdp_pin_sync.sv */
/*
 Three-stage pin synchroniser with agreement filter. Assumes pins are
 asynchronous to core_clk.
*/
module gdp_pin_sync #(
    parameter int WIDTH = 40
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] pin_raw,
    output logic      [WIDTH-1:0] pin_level,
    output logic      [WIDTH-1:0] pin_change
);
    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;
    logic [WIDTH-1:0] stage_three;
    logic [1:0]       fill;
    wire              primed     = fill == 2'h3;
    wire  [WIDTH-1:0] agree      = ~(stage_two ^ stage_three);
    wire  [WIDTH-1:0] next_level = (agree & stage_three) | (~agree & pin_level);

    // The first stage feeds only the second; a level counts when two and three agree.
    // Until the stages hold real samples the level is loaded quietly, because a reset
    // level of zero would otherwise look like an edge on every pin that idles high.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stage_one   <= '0;
            stage_two   <= '0;
            stage_three <= '0;
            pin_level   <= '0;
            fill        <= 2'h0;
        end
        else
        begin
            stage_one   <= pin_raw;
            stage_two   <= stage_one;
            stage_three <= stage_two;
            pin_level   <= primed ? next_level : stage_two;
            fill        <= primed ? fill : fill + 2'h1;
        end
    end

    // No change is reported while the stages are still filling after reset.
    assign pin_change = primed ? (next_level ^ pin_level) : '0;
endmodule // gdp_pin_sync

/* rtl/gdp_cfg_mem.sv */
/*
 Small memory holding one configuration byte per port with registered read.
 Assumes single write and single read port on core_clk.
*/
module gdp_cfg_mem #(
    parameter int DEPTH = 40
) (
    input  wire logic                     core_clk,
    input  wire logic                     rstn,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input  wire logic [7:0]               wr_data,
    input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic      [7:0]               rd_data,
    output logic      [DEPTH*8-1:0]       all_cfg
);
    localparam int IW = $clog2(DEPTH);
    logic [7:0] cfg [DEPTH];

    // An index narrower than one bit cannot address the store.
    if (DEPTH < 2)
    begin : g_chk
        $error("Configuration depth must be at least two.");
    end

    // input after reset
    // Every port resets to an input so nothing drives a pin after power-on.
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_cfg
        always_ff @(posedge core_clk or negedge rstn)
        begin
            if (!rstn)
                cfg[i] <= gdp_pkg::CFG_RESET;
            else if (wr_en && wr_idx == IW'(i))
                cfg[i] <= wr_data;
        end
        assign all_cfg[i*8 +: 8] = cfg[i];
    end

    // Read data comes out of a register.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rd_data <= 8'h00;
        else
            rd_data <= cfg[rd_idx];
    end
endmodule // gdp_cfg_mem

/* rtl/gdp_port_bank.sv */
/*
 General purpose port bank: 40 ports, 36 of them in five packed data registers, one
 configuration byte per port, pin synchronisers and pin-change interrupts.
 Assumes a plain register port with read data one cycle after the read strobe,
 and external pads that resolve pin level from data out and low-active enable.
*/
// Implementation choice: the plain strobed port.
// Contract
// - Each port has one data bit and its own eight-bit configuration register.
// - Data bits pack into eight-bit data registers at fixed bit positions.
// - Input port read returns the present pin level.
// - Output port drives the value software wrote to its data bit.
// - Data bit latched on every read and write, stable between accesses.
// - All data and configuration registers are reachable in the register space.
// - Data registers at 4B to 4F; register four bits 4 to 7 reserved.
// - Event-capable inputs feed wakeup logic kept on standby supply.
// - Config bit 0 direction, bit 1 polarity, bit 7 open-drain select.
module gdp_port_bank #(
    parameter int NPORT = 40
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [7:0]       reg_rdata,
    input  wire logic [NPORT-1:0] pin_in,
    output logic      [NPORT-1:0] pin_out,
    output logic      [NPORT-1:0] pin_oe_n,
    output logic      [NPORT-1:0] wakeup_event_in,
    output logic                  irq
);
    localparam int IW = $clog2(NPORT);

    if (NPORT != gdp_pkg::NUM_PORTS)
    begin : g_chk
        $error("Port count must be 40.");
    end

    logic [NPORT-1:0]   out_val;
    logic [NPORT-1:0]   latched;
    logic [NPORT-1:0]   irq_stat;
    logic [NPORT-1:0]   irq_mask;
    logic [NPORT-1:0]   pin_level;
    logic [NPORT-1:0]   pin_change;
    logic [NPORT*8-1:0] all_cfg;
    logic [7:0]         cfg_rdata;
    logic [7:0]         rd_hold;
    logic               rd_from_cfg;

    gdp_pin_sync #(.WIDTH(NPORT)) u_sync (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .pin_raw    (pin_in),
        .pin_level  (pin_level),
        .pin_change (pin_change)
    );

    // Configuration window decode.
    wire         cfg_hit = reg_addr >= gdp_pkg::CFG_BASE_OFS
                           && reg_addr < gdp_pkg::CFG_BASE_OFS + 8'(NPORT);
    wire [7:0]   cfg_off = reg_addr - gdp_pkg::CFG_BASE_OFS;
    wire [IW-1:0] cfg_idx = cfg_off[IW-1:0];

    gdp_cfg_mem #(.DEPTH(NPORT)) u_cfg (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wr_en    (reg_wr && cfg_hit),
        .wr_idx   (cfg_idx),
        .wr_data  (reg_wdata),
        .rd_idx   (cfg_idx),
        .rd_data  (cfg_rdata),
        .all_cfg  (all_cfg)
    );

    // Per-port field extraction and pin drive.
    logic [NPORT-1:0] dir_out;
    logic [NPORT-1:0] pol_inv;
    logic [NPORT-1:0] odrain;
    logic [NPORT-1:0] drive_val;
    logic [NPORT-1:0] in_val;
    for (genvar p = 0; p < NPORT; p++)
    begin : g_port
        assign dir_out[p]   = ~all_cfg[p*8 + gdp_pkg::CFG_DIR_BIT];
        assign pol_inv[p]   = all_cfg[p*8 + gdp_pkg::CFG_POL_BIT];
        assign odrain[p]    = all_cfg[p*8 + gdp_pkg::CFG_ODRAIN_BIT];
        assign drive_val[p] = out_val[p] ^ pol_inv[p];
        // open-drain drives low only; push-pull drives both levels.
        assign pin_out[p]   = odrain[p] ? 1'b0 : drive_val[p];
        assign pin_oe_n[p]  = ~(dir_out[p] && (!odrain[p] || !drive_val[p]));
        assign in_val[p]    = pin_level[p] ^ pol_inv[p];
    end

    // wakeup path taken before synchronisers, as the standby logic has no core clock.
    assign wakeup_event_in = pin_in;

    // Data register decode.
    wire [2:0] data_sel = reg_addr == gdp_pkg::DATA_ONE_OFS   ? 3'h1 :
                          reg_addr == gdp_pkg::DATA_TWO_OFS   ? 3'h2 :
                          reg_addr == gdp_pkg::DATA_THREE_OFS ? 3'h3 :
                          reg_addr == gdp_pkg::DATA_FOUR_OFS  ? 3'h4 :
                          reg_addr == gdp_pkg::DATA_FIVE_OFS  ? 3'h5 : 3'h0;
    // Interrupt register decode: stat at 60..63,68; mask at 64..67,69.
    wire [2:0] stat_sel = reg_addr == gdp_pkg::IRQ_STAT_OFS  ? 3'h1 :
                          reg_addr == gdp_pkg::IRQ_STAT2_OFS ? 3'h2 :
                          reg_addr == gdp_pkg::IRQ_STAT3_OFS ? 3'h3 :
                          reg_addr == gdp_pkg::IRQ_STAT4_OFS ? 3'h4 :
                          reg_addr == gdp_pkg::IRQ_STAT5_OFS ? 3'h5 : 3'h0;
    wire [2:0] mask_sel = reg_addr == gdp_pkg::IRQ_MASK_OFS  ? 3'h1 :
                          reg_addr == gdp_pkg::IRQ_MASK2_OFS ? 3'h2 :
                          reg_addr == gdp_pkg::IRQ_MASK3_OFS ? 3'h3 :
                          reg_addr == gdp_pkg::IRQ_MASK4_OFS ? 3'h4 :
                          reg_addr == gdp_pkg::IRQ_MASK5_OFS ? 3'h5 : 3'h0;

    // Byte-wide write masks into the packed 40-bit vectors.
    logic [NPORT-1:0] wr_data_vec;
    logic [NPORT-1:0] data_we;
    logic [NPORT-1:0] stat_we;
    logic [NPORT-1:0] mask_we;
    logic [NPORT-1:0] acc_lane;
    // reserved upper nibble of register four
    wire  [7:0]       lane_valid = data_sel == 3'h4 ? gdp_pkg::FOUR_VALID_MASK : 8'hff;
    for (genvar b = 0; b < NPORT / 8; b++)
    begin : g_lane
        assign wr_data_vec[b*8 +: 8] = reg_wdata;
        assign acc_lane[b*8 +: 8] = (data_sel == 3'(b + 1)) ? lane_valid : 8'h00;
        assign data_we[b*8 +: 8]  = reg_wr ? acc_lane[b*8 +: 8] : 8'h00;
        assign stat_we[b*8 +: 8]  = (reg_wr && stat_sel == 3'(b + 1)) ? reg_wdata : 8'h00;
        assign mask_we[b*8 +: 8]  = (reg_wr && mask_sel == 3'(b + 1)) ? 8'hff : 8'h00;
    end

    // latch on read and on write
    wire [NPORT-1:0] rd_lane = reg_rd ? acc_lane : '0;
    wire [NPORT-1:0] acc_any = rd_lane | data_we;
    wire [NPORT-1:0] cur_val = (dir_out & out_val) | (~dir_out & in_val);
    wire [NPORT-1:0] next_latched = (data_we & wr_data_vec) | (~data_we & rd_lane & cur_val)
                                    | (~acc_any & latched);
    // input pin events set status; a clear in the same cycle loses.
    wire [NPORT-1:0] in_event  = pin_change & ~dir_out;
    wire [NPORT-1:0] next_stat = (irq_stat & ~stat_we) | in_event;

    // Data, status and mask storage.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_val  <= '0;
            latched  <= '0;
            irq_stat <= '0;
            irq_mask <= '0;
        end
        else
        begin
            out_val  <= (data_we & wr_data_vec) | (~data_we & out_val);
            latched  <= next_latched;
            irq_stat <= next_stat;
            irq_mask <= (mask_we & wr_data_vec) | (~mask_we & irq_mask);
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // Read mux: data reads return the freshly latched byte.
    wire [2:0] rsel = data_sel | stat_sel | mask_sel;
    wire [5:0] rbase = {3'h0, rsel - 3'h1} << 3;
    wire [7:0] next_rd = data_sel != 3'h0 ? next_latched[rbase +: 8] & lane_valid :
                         stat_sel != 3'h0 ? irq_stat[rbase +: 8] :
                         mask_sel != 3'h0 ? irq_mask[rbase +: 8] : 8'h00;

    // Read holding register; unmapped addresses read zero.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_hold     <= 8'h00;
            rd_from_cfg <= 1'b0;
        end
        else
        begin
            rd_hold     <= reg_rd ? next_rd : 8'h00;
            rd_from_cfg <= reg_rd && cfg_hit;
        end
    end

    assign reg_rdata = rd_from_cfg ? cfg_rdata : rd_hold;

    // Helper history for assertions.
    logic [7:0] prev_addr;
    logic       prev_wr;
    logic [7:0] prev_wdata;
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_addr  <= 8'h00;
            prev_wr    <= 1'b0;
            prev_wdata <= 8'h00;
        end
        else
        begin
            prev_addr  <= reg_addr;
            prev_wr    <= reg_wr;
            prev_wdata <= reg_wdata;
        end
    end

    sequence s_write_one;
        reg_wr && reg_addr == gdp_pkg::DATA_ONE_OFS;
    endsequence

    sequence s_read_one;
        reg_rd && reg_addr == gdp_pkg::DATA_ONE_OFS;
    endsequence

    // An event counts only if no mask write can hide it at the same edge.
    sequence s_masked_event;
        (in_event & irq_mask) != '0 && !(reg_wr && mask_sel != 3'h0);
    endsequence

    sequence s_cfg_write;
        reg_wr && cfg_hit;
    endsequence

    sequence s_cfg_read;
        reg_rd && cfg_hit && !(prev_wr && prev_addr == reg_addr);
    endsequence

    sequence s_unmapped_read;
        reg_rd && !cfg_hit && rsel == 3'h0;
    endsequence

    cfg_reset_in_a: assert property (@(posedge core_clk) $rose(rstn) |-> pin_oe_n == '1)
        else $error("Port driven right after reset.");
    data_wr_lat_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_write_one |=> latched[7:0] == $past(reg_wdata))
        else $error("Write not latched.");
    data_drive_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_write_one |=> !(dir_out[0] && !odrain[0] && !pol_inv[0]) || pin_out[0] == prev_wdata[0])
        else $error("Output does not follow written value.");
    rd_latency_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_read_one |=> reg_rdata == latched[7:0])
        else $error("Read data not latched value.");
    four_resv_a: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_rd && reg_addr == gdp_pkg::DATA_FOUR_OFS |=> reg_rdata[7:4] == 4'h0)
        else $error("Reserved bits read non-zero.");
    latch_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !(reg_rd || reg_wr) |=> $stable(latched))
        else $error("Latch changed without access.");
    odrain_high_a: assert property (@(posedge core_clk) disable iff (!rstn)
        odrain != '0 |-> (pin_out & odrain) == '0)
        else $error("Open-drain pin drives high.");
    input_nodrv_a: assert property (@(posedge core_clk) disable iff (!rstn)
        (~dir_out & ~pin_oe_n) == '0)
        else $error("Input port drives its pin.");
    irq_level_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_masked_event |=> irq)
        else $error("Unmasked pin event gave no interrupt.");
    cfg_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_cfg_read |=> reg_rdata == all_cfg[$past(cfg_idx)*8 +: 8])
        else $error("Config read wrong.");
    cfg_wr_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_cfg_write |=> all_cfg[$past(cfg_idx)*8 +: 8] == $past(reg_wdata))
        else $error("Config write lost.");
    four_wr_a: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_wr && reg_addr == gdp_pkg::DATA_FOUR_OFS |=> $stable(out_val[31:28]))
        else $error("Reserved data bits written.");
    unmap_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_unmapped_read |=> reg_rdata == 8'h00)
        else $error("Unmapped address read non-zero.");
    rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("Read data outside the read cycle.");
    in_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_read_one ##0 !dir_out[0] |=> reg_rdata[0] == $past(in_val[0]))
        else $error("Input read does not follow pin.");
    out_rd_a: assert property (@(posedge core_clk) disable iff (!rstn)
        s_read_one ##0 dir_out[0] |=> reg_rdata[0] == $past(out_val[0]))
        else $error("Output read does not return written value.");
    stat_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
        in_event != '0 |=> (irq_stat & $past(in_event)) == $past(in_event))
        else $error("Pin event lost from status.");
    mask_wr_a: assert property (@(posedge core_clk) disable iff (!rstn)
        reg_wr && mask_sel != 3'h0 |=> irq_mask[$past(rbase) +: 8] == $past(reg_wdata))
        else $error("Mask write lost.");
    irq_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
        !irq && (in_event & irq_mask) == '0 && !(reg_wr && mask_sel != 3'h0) |=> !irq)
        else $error("Interrupt rose without an unmasked event.");
endmodule // gdp_port_bank

/* tb/gdp_pad_model.sv */
/*
 Board-side pad model for the port bank: resolves each pin from the device
 drive and the level the board applies. Assumes low-active output enables.
*/
module gdp_pad_model #(
    parameter int N = 40
) (
    input  wire logic [N-1:0] pin_out,
    input  wire logic [N-1:0] pin_oe_n,
    input  wire logic [N-1:0] ext_lvl,
    output logic      [N-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    // A released pin shows the board level, which also stands for a pull-up.
    assign pin_in = (pin_oe_n & ext_lvl) | (~pin_oe_n & pin_out);
endmodule // gdp_pad_model

/* tb/tb_top.sv */
/*
 Self-checking bench for the port bank: register accesses, pin levels and
 interrupt. Assumes the design files and package are compiled first.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk  = 1'b0;
    logic        rstn      = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [7:0]  reg_rdata;
    logic [39:0] ext_lvl   = '1;
    logic [39:0] pin_in;
    logic [39:0] pin_out;
    logic [39:0] pin_oe_n;
    logic [39:0] wake;
    logic        irq;
    logic        rd_pend   = 1'b0;
    logic [31:0] seed      = 32'h7e7b;
    logic [7:0]  exp_q[$];
    logic [7:0]  v;
    logic [7:0]  e;
    int          n_mismatch   = 0;
    int          total_checks = 0;

    // Free-running core clock at 4 ns.
    always #2 core_clk = ~core_clk;

    gdp_port_bank #(.NPORT(40)) u_gdp_port_bank (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .wakeup_event_in(wake), .irq(irq)
    );
    gdp_pad_model #(.N(40)) u_gdp_pad_model (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_lvl(ext_lvl), .pin_in(pin_in)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One strobe setting per edge, so back-to-back accesses never reassign.
    task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= w;
        reg_rd    <= r;
        reg_addr  <= a;
        reg_wdata <= d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        acc(1'b0, 1'b1, a, 8'h00);
    endtask

    task automatic idle(input int n);
        repeat (n) acc(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
    always @(posedge core_clk) rd_pend <= reg_rd;
    always @(negedge core_clk)
    begin
        if (rd_pend)
        begin
            if (exp_q.size() == 0)
                chk("read queue", 40'h1, 40'h0);
            else
                chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    // Watchdog sized well beyond the roughly seventy cycles of the sequence.
    initial
    begin
        #20000;
        n_mismatch++;
        stop_test();
    end

    // Main sequence.
    initial
    begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        chk("pin_oe_n after reset", '1, pin_oe_n);
        rd(gdp_pkg::CFG_BASE_OFS, gdp_pkg::CFG_RESET);
        rd(8'ha7, gdp_pkg::CFG_RESET);
        acc(1'b1, 1'b0, 8'h89, 8'h03);
        seed = xs(seed);
        ext_lvl[31:0] <= seed;
        seed = xs(seed);
        ext_lvl[39:32] <= seed[7:0];
        idle(8);
        // Every data register packs eight ports; register four keeps only four.
        for (int n = 0; n < 5; n++)
        begin
            e = ext_lvl[n*8 +: 8];
            if (n == 1) e ^= 8'h02;
            if (n == 3) e &= gdp_pkg::FOUR_VALID_MASK;
            rd(gdp_pkg::DATA_ONE_OFS + 8'(n), e);
        end
        rd(8'h40, 8'h00);
        idle(2);
        chk("wakeup_event_in", pin_in, wake);
        // Port 1 inverted, port 2 open drain, the rest of 0 to 7 and 24 to 27 push-pull outputs.
        for (int i = 0; i < 8; i++)
            acc(1'b1, 1'b0, 8'h80 + 8'(i), (i == 1) ? 8'h02 : (i == 2) ? 8'h80 : 8'h00);
        for (int i = 24; i < 28; i++)
            acc(1'b1, 1'b0, 8'h80 + 8'(i), 8'h00);
        seed = xs(seed);
        v = seed[7:0];
        ext_lvl[2] <= 1'b1;
        acc(1'b1, 1'b0, gdp_pkg::DATA_ONE_OFS, v);
        acc(1'b1, 1'b0, gdp_pkg::DATA_FOUR_OFS, 8'hff);
        idle(2);
        chk("pin_out 0", v[0], pin_out[0]);
        chk("pin_out 1", !v[1], pin_out[1]);
        chk("open drain pin", v[2], pin_in[2]);
        chk("pin_oe_n 1:0", 2'b00, pin_oe_n[1:0]);
        chk("pin_oe_n 27:24", 4'h0, pin_oe_n[27:24]);
        rd(gdp_pkg::DATA_ONE_OFS, v);
        rd(gdp_pkg::DATA_FOUR_OFS, gdp_pkg::FOUR_VALID_MASK);
        idle(2);
        // Pin-change interrupt on port 8: raise, read, clear, then masked.
        acc(1'b1, 1'b0, gdp_pkg::IRQ_STAT2_OFS, 8'hff);
        acc(1'b1, 1'b0, gdp_pkg::IRQ_MASK2_OFS, 8'h01);
        idle(2);
        chk("irq idle", 1'b0, irq);
        ext_lvl[8] <= ~ext_lvl[8];
        idle(8);
        chk("irq raised", 1'b1, irq);
        rd(gdp_pkg::IRQ_STAT2_OFS, 8'h01);
        acc(1'b1, 1'b0, gdp_pkg::IRQ_STAT2_OFS, 8'h01);
        idle(2);
        chk("irq cleared", 1'b0, irq);
        acc(1'b1, 1'b0, gdp_pkg::IRQ_MASK2_OFS, 8'h00);
        ext_lvl[8] <= ~ext_lvl[8];
        idle(8);
        chk("irq masked", 1'b0, irq);
        rd(gdp_pkg::IRQ_STAT2_OFS, 8'h01);
        idle(2);
        stop_test();
    end
endmodule // tb_top
